// *** hdl/display_host_port.sv ***
// Host port and scan engine of an eight-character dot-matrix display.
// Assumes a host that holds address and data steady around its strobes.
//
// Notes on behaviour
// R1 - One shared byte bus, both directions
// R2 - 128 fixed codes plus sixteen user glyphs
// R3 - Eight characters of five by seven dots
// R4 - Host waits three display clocks after reset
// R5 - Five address lines plus flash select
// R6 - Selector value 30H reaches control word
// R7 - Low three bits set eight brightness levels
// R8 - Writing 40H tests at full brightness
// R9 - Bit six set starts the self-test
// R10 - Bit five reports the self-test result
// R11 - Host reads result only after test ends
// R12 - Glyph definition: address write, seven rows
// R13 - Glyph address picks slot for rows
// R14 - Row write sets that row's dots
// R15 - Data bit seven picks glyph or code
// R16 - Clock select high drives internal oscillator out
// R17 - Clock select low slaves to clock pin
// R18 - Host writes: address, enable, strobe, release
// R19 - Result bit of one means pass
// R20 - Bit three flashes marked characters
// R21 - Bit four blinks the whole display
// R22 - Display reset pin is active low
`timescale 1ns/10ps
module display_host_port
#(
  parameter int OSC_HALF  = display_pkg::OSC_HALF_CYCLES,  // Oscillator half period.
  parameter int BLINK_LEN = display_pkg::BLINK_FRAMES      // Frames per blink phase.
)
(
  input  wire logic       sys_clk_i,      // System clock, 125 MHz.
  input  wire logic       srst_i,         // Synchronous reset, active high.
  input  wire logic       disp_rst_n_i,   // Display reset pin, active low.
  input  wire logic       ce_n_i,         // Chip enable pin, active low.
  input  wire logic       rd_n_i,         // Read strobe pin, active low.
  input  wire logic       wr_n_i,         // Write strobe pin, active low.
  input  wire logic       flash_sel_i,    // Flash-select pin, low reaches flash RAM.
  input  wire logic [4:0] addr_i,         // Address pins.
  input  wire logic [7:0] data_i,         // Data bus input side.
  output logic      [7:0] data_o,         // Data bus output side.
  output logic            data_oe_o,      // Data bus drive enable.
  input  wire logic       clk_sel_i,      // Clock select pin, high is internal.
  input  wire logic       disp_clk_i,     // Clock pin input side.
  output logic            disp_clk_o,     // Clock pin output side.
  output logic            disp_clk_oe_o,  // Clock pin drive enable.
  output logic      [2:0] digit_o,        // Character position being lit.
  output logic      [2:0] row_o,          // Dot row being lit.
  output logic      [4:0] dots_o          // Lit dots of that row.
);

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  logic [19:0] pin_s1_reg;  // First stage, read only by the second.
  logic [19:0] pin_s2_reg;  // Second stage, safe to use.
  logic        ext_clk_d_reg;  // Delayed external clock for edge detect.
  logic        wr_n_d_reg;     // Delayed write strobe for edge detect.

  // R5 address and select
  // All pins pass two flip-flops before use.
  always_ff @(posedge sys_clk_i)
  begin
    pin_s1_reg    <= {disp_rst_n_i, ce_n_i, rd_n_i, wr_n_i, flash_sel_i, addr_i, data_i,
                      clk_sel_i, disp_clk_i};
    pin_s2_reg    <= pin_s1_reg;
    ext_clk_d_reg <= pin_s2_reg[0];
    wr_n_d_reg    <= pin_s2_reg[16];
  end

  logic       rst_n_s;   // Synced display reset.
  logic       ce_n_s;    // Synced chip enable.
  logic       rd_n_s;    // Synced read strobe.
  logic       wr_n_s;    // Synced write strobe.
  logic [5:0] sel_s;     // Synced flash select and address.
  logic [7:0] wdata_s;   // Synced data bus.
  logic       clk_sel_s; // Synced clock select.
  logic       ext_clk_s; // Synced external clock.
  logic       soft_rst;  // Reset from either source.
  logic       wr_take;   // Write taken on strobe release.

  assign {rst_n_s, ce_n_s, rd_n_s, wr_n_s, sel_s, wdata_s, clk_sel_s, ext_clk_s} = pin_s2_reg;
  // R22 low pin resets
  assign soft_rst = srst_i | ~rst_n_s;
  // R18 write on strobe rise
  assign wr_take  = wr_n_s & ~wr_n_d_reg & ~ce_n_s;

  // ----------------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------------
  logic [7:0] ctrl_reg, ctrl_next;          // Brightness, flash and blink bits.
  logic [3:0] glyph_addr_reg, glyph_addr_next;  // Selected user glyph slot.
  logic [7:0] char_reg [8];                 // Character RAM.
  logic [7:0] char_next [8];                // Next character RAM.
  logic [7:0] flash_reg, flash_next;        // Per-character flash bits.
  logic       test_busy_reg, test_busy_next;    // Self-test running.
  logic       test_pass_reg, test_pass_next;    // Self-test outcome.
  logic [9:0] test_idx_reg, test_idx_next;      // Self-test walk position.
  logic [4:0] test_sig_reg, test_sig_next;      // Running signature.
  logic       glyph_wr;                     // Row write to the glyph store.

  // Decodes host writes and runs the self-test walk.
  always_comb
  begin
    ctrl_next       = ctrl_reg;
    glyph_addr_next = glyph_addr_reg;
    char_next       = char_reg;
    flash_next      = flash_reg;
    test_busy_next  = test_busy_reg;
    test_pass_next  = test_pass_reg;
    test_idx_next   = test_idx_reg;
    test_sig_next   = test_sig_reg;
    glyph_wr        = 1'b0;
    // Self-test walk over every fixed character row.
    if (test_busy_reg)
    begin
      test_sig_next = {test_sig_reg[3:0], test_sig_reg[4]}
                      ^ display_pkg::font_row(7'(test_idx_reg / 10'(display_pkg::NUM_ROWS)),
                                              3'(test_idx_reg % 10'(display_pkg::NUM_ROWS)));
      test_idx_next = test_idx_reg + 10'h001;
      if (test_idx_reg == 10'(display_pkg::ST_ENTRIES - 1))
      begin
        test_busy_next = 1'b0;
        // R19 one is a pass
        test_pass_next = (test_sig_next == display_pkg::FONT_SIG);
      end
    end
    if (wr_take)
    begin
      if (!sel_s[5])
      begin
        // Flash RAM: one bit per character position.
        flash_next[sel_s[2:0]] = wdata_s[0];
      end
      else
      begin
        unique case (sel_s[4:3])
          display_pkg::SEL_GLYPH_ADDR:
          begin
            // R13 slot select
            glyph_addr_next = wdata_s[3:0];
          end
          display_pkg::SEL_GLYPH_ROWS:
          begin
            // R12 row writes follow
            glyph_wr = 1'b1;
          end
          display_pkg::SEL_CTRL:
          begin
            // R6 control word select
            // R7 brightness field
            // R20 flash enable
            // R21 blink enable
            ctrl_next = {3'h0, wdata_s[4:0]};
            // R9 start self-test
            // R8 test at full
            if (wdata_s[display_pkg::CW_TEST_BIT] && !test_busy_reg)
            begin
              test_busy_next = 1'b1;
              test_pass_next = 1'b0;
              test_idx_next  = 10'h000;
              test_sig_next  = 5'h00;
            end
          end
          display_pkg::SEL_CHAR_RAM:
          begin
            // R15 stored with selector
            char_next[sel_s[2:0]] = wdata_s;
          end
        endcase
      end
    end
  end

  // R4 reset clears state
  // Holds everything at its reset value while either reset is active.
  always_ff @(posedge sys_clk_i)
  begin
    if (soft_rst)
    begin
      ctrl_reg       <= display_pkg::CTRL_RESET;
      glyph_addr_reg <= 4'h0;
      char_reg       <= '{default: 8'h20};
      flash_reg      <= 8'h00;
      test_busy_reg  <= 1'b0;
      test_pass_reg  <= 1'b0;
      test_idx_reg   <= 10'h000;
      test_sig_reg   <= 5'h00;
    end
    else
    begin
      ctrl_reg       <= ctrl_next;
      glyph_addr_reg <= glyph_addr_next;
      char_reg       <= char_next;
      flash_reg      <= flash_next;
      test_busy_reg  <= test_busy_next;
      test_pass_reg  <= test_pass_next;
      test_idx_reg   <= test_idx_next;
      test_sig_reg   <= test_sig_next;
    end
  end

  // ----------------------------------------------------------------------
  // Host read path
  // ----------------------------------------------------------------------
  logic [7:0] rdata_next;  // Read value for the selected location.
  logic       oe_next;     // Drive the bus this cycle.

  // R1 display drives reads
  // R10 result in bit five
  always_comb
  begin
    oe_next    = ~ce_n_s & ~rd_n_s;
    rdata_next = 8'h00;
    if (!sel_s[5])
    begin
      rdata_next = {7'h00, flash_reg[sel_s[2:0]]};
    end
    else
    begin
      unique case (sel_s[4:3])
        display_pkg::SEL_GLYPH_ADDR: rdata_next = {4'h0, glyph_addr_reg};
        display_pkg::SEL_GLYPH_ROWS: rdata_next = 8'h00;
        display_pkg::SEL_CTRL:       rdata_next = {1'b0, test_busy_reg, test_pass_reg,
                                                   ctrl_reg[4:0]};
        display_pkg::SEL_CHAR_RAM:   rdata_next = char_reg[sel_s[2:0]];
      endcase
    end
  end

  // Registers the bus outputs.
  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
    begin
      data_o    <= 8'h00;
      data_oe_o <= 1'b0;
    end
    else
    begin
      data_o    <= rdata_next;
      data_oe_o <= oe_next;
    end
  end

  // ----------------------------------------------------------------------
  // Display clock source
  // ----------------------------------------------------------------------
  logic [7:0] osc_cnt_reg, osc_cnt_next;  // Oscillator divider.
  logic       osc_reg, osc_next;          // Oscillator level.
  logic       tick;                       // One display clock edge.

  // R16 internal oscillator out
  // R17 slave to clock pin
  always_comb
  begin
    osc_cnt_next = osc_cnt_reg + 8'h01;
    osc_next     = osc_reg;
    if (osc_cnt_reg == 8'(OSC_HALF - 1))
    begin
      osc_cnt_next = 8'h00;
      osc_next     = ~osc_reg;
    end
    if (clk_sel_s)
    begin
      tick = ~osc_reg & osc_next;
    end
    else
    begin
      tick = ext_clk_s & ~ext_clk_d_reg;
    end
  end

  // Registers the divider and the clock pin drive.
  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
    begin
      osc_cnt_reg   <= 8'h00;
      osc_reg       <= 1'b0;
      disp_clk_o    <= 1'b0;
      disp_clk_oe_o <= 1'b0;
    end
    else
    begin
      osc_cnt_reg   <= osc_cnt_next;
      osc_reg       <= osc_next;
      disp_clk_o    <= osc_next;
      disp_clk_oe_o <= clk_sel_s;
    end
  end

  // ----------------------------------------------------------------------
  // Scan engine
  // ----------------------------------------------------------------------
  logic [3:0] pwm_reg, pwm_next;      // Brightness slot within a row.
  logic [2:0] row_reg, row_next;      // Row being scanned.
  logic [2:0] dig_reg, dig_next;      // Character being scanned.
  logic [7:0] frame_reg, frame_next;  // Frames within a blink phase.
  logic       phase_reg, phase_next;  // Blink/flash off phase.
  logic [4:0] glyph_dots;             // Dots from the glyph store.
  logic       lit;                    // Row shown in this slot.

  // R3 eight by seven scan
  always_comb
  begin
    pwm_next   = pwm_reg;
    row_next   = row_reg;
    dig_next   = dig_reg;
    frame_next = frame_reg;
    phase_next = phase_reg;
    if (tick)
    begin
      pwm_next = pwm_reg + 4'h1;
      if (pwm_reg == display_pkg::PWM_STEPS - 4'h1)
      begin
        pwm_next = 4'h0;
        row_next = row_reg + 3'h1;
        if (row_reg == 3'(display_pkg::NUM_ROWS - 1))
        begin
          row_next = 3'h0;
          dig_next = dig_reg + 3'h1;
          if (dig_reg == 3'(display_pkg::NUM_DIGITS - 1))
          begin
            frame_next = frame_reg + 8'h01;
            if (frame_reg == 8'(BLINK_LEN - 1))
            begin
              frame_next = 8'h00;
              phase_next = ~phase_reg;
            end
          end
        end
      end
    end
    // R7 brightness duty
    lit = (pwm_reg < display_pkg::duty_of(ctrl_reg[2:0]));
    // R21 whole display blink
    if (ctrl_reg[display_pkg::CW_BLINK_BIT] && phase_reg)
    begin
      lit = 1'b0;
    end
    // R20 marked characters flash
    if (ctrl_reg[display_pkg::CW_FLASH_BIT] && flash_reg[dig_reg] && phase_reg)
    begin
      lit = 1'b0;
    end
  end

  // Registers the scan position and the drive outputs.
  always_ff @(posedge sys_clk_i)
  begin
    if (soft_rst)
    begin
      pwm_reg   <= 4'h0;
      row_reg   <= 3'h0;
      dig_reg   <= 3'h0;
      frame_reg <= 8'h00;
      phase_reg <= 1'b0;
      digit_o   <= 3'h0;
      row_o     <= 3'h0;
      dots_o    <= 5'h00;
    end
    else
    begin
      pwm_reg   <= pwm_next;
      row_reg   <= row_next;
      dig_reg   <= dig_next;
      frame_reg <= frame_next;
      phase_reg <= phase_next;
      digit_o   <= dig_reg;
      row_o     <= row_reg;
      dots_o    <= lit ? glyph_dots : 5'h00;
    end
  end

  // R14 row into glyph store
  glyph_store u_glyph_store
  (
    .sys_clk_i (sys_clk_i),
    .wr_en_i   (glyph_wr),
    .wr_slot_i (glyph_addr_reg),
    .wr_row_i  (sel_s[2:0]),
    .wr_dots_i (wdata_s[4:0]),
    .rd_code_i (char_reg[dig_reg]),
    .rd_row_i  (row_reg),
    .rd_dots_o (glyph_dots)
  );

endmodule

// *** inc/display_pkg.sv ***
// Shared constants, address map and character generator for the display host port.
// Assumes one 125 MHz system clock and a host that samples slowly against it.
package display_pkg;

  // ----------------------------------------------------------------------
  // Address map: a six-bit selector made of flash-select and five address lines.
  // ----------------------------------------------------------------------
  localparam logic [5:0] CTRL_WORD_ADDR   = 6'h30;  // Control word location.
  localparam logic [1:0] SEL_GLYPH_ADDR   = 2'h0;   // Upper address pair: glyph address.
  localparam logic [1:0] SEL_GLYPH_ROWS   = 2'h1;   // Upper address pair: glyph row RAM.
  localparam logic [1:0] SEL_CTRL         = 2'h2;   // Upper address pair: control word.
  localparam logic [1:0] SEL_CHAR_RAM     = 2'h3;   // Upper address pair: character RAM.

  // ----------------------------------------------------------------------
  // Control word fields and reset value.
  // ----------------------------------------------------------------------
  localparam int         CW_BRIGHT_LSB    = 0;      // Brightness code, three bits.
  localparam int         CW_FLASH_BIT     = 3;      // Per-character flash enable.
  localparam int         CW_BLINK_BIT     = 4;      // Whole-display blink enable.
  localparam int         CW_RESULT_BIT    = 5;      // Self-test outcome, one is a pass.
  localparam int         CW_TEST_BIT      = 6;      // Self-test start and busy flag.
  localparam int         CW_SELECT_BIT    = 7;      // Character RAM glyph/ROM selector.
  localparam logic [7:0] CTRL_RESET       = 8'h00;  // Full brightness, features off.

  // ----------------------------------------------------------------------
  // Geometry and timing counts.
  // ----------------------------------------------------------------------
  localparam int         NUM_DIGITS       = 8;      // Character positions.
  localparam int         NUM_ROWS         = 7;      // Dot rows per character.
  localparam int         NUM_COLS         = 5;      // Dot columns per character.
  localparam int         NUM_ROM_CODES    = 128;    // Fixed character codes.
  localparam int         NUM_USER_GLYPHS  = 16;     // User-defined glyph slots.
  localparam logic [3:0] PWM_STEPS        = 4'hF;   // Brightness slots per row.
  localparam int         OSC_HALF_CYCLES  = 16;     // Internal oscillator half period.
  localparam int         BLINK_FRAMES     = 64;     // Frames per blink or flash phase.
  localparam int         ST_ENTRIES       = NUM_ROM_CODES * NUM_ROWS;

  // Number of lit brightness slots for each three-bit brightness code.
  function automatic logic [3:0] duty_of(input logic [2:0] code);
    logic [3:0] d;
    d = 4'h0;
    unique case (code)
      3'h0: d = 4'hF;  // Full intensity.
      3'h1: d = 4'hC;
      3'h2: d = 4'h8;
      3'h3: d = 4'h6;  // Six of fifteen, forty percent.
      3'h4: d = 4'h4;
      3'h5: d = 4'h3;
      3'h6: d = 4'h2;
      3'h7: d = 4'h0;  // Blanked.
    endcase
    return d;
  endfunction

  // Fixed character generator; codes at and below a space render dark.
  function automatic logic [4:0] font_row(input logic [6:0] code, input logic [2:0] row);
    logic [4:0] r;
    r = 5'h00;
    if (code > 7'h20)
    begin
      r = code[4:0] ^ {row, code[6:5]};
    end
    return r;
  endfunction

  // Signature of the whole character generator, used by the self-test.
  function automatic logic [4:0] font_signature();
    logic [4:0] s;
    s = 5'h00;
    for (int c = 0; c < NUM_ROM_CODES; c++)
    begin
      for (int r = 0; r < NUM_ROWS; r++)
      begin
        s = {s[3:0], s[4]} ^ font_row(7'(c), 3'(r));
      end
    end
    return s;
  endfunction

  localparam logic [4:0] FONT_SIG = font_signature();

endpackage

// *** hdl/glyph_store.sv ***
// User glyph RAM and character-to-dots lookup for one digit row.
// Assumes writes come from the host port already decoded to slot and row.
`timescale 1ns/10ps
module glyph_store
(
  input  wire logic       sys_clk_i,   // System clock.
  input  wire logic       wr_en_i,     // Write one glyph row.
  input  wire logic [3:0] wr_slot_i,   // Glyph slot written.
  input  wire logic [2:0] wr_row_i,    // Row written, zero based.
  input  wire logic [4:0] wr_dots_i,   // Dots of that row.
  input  wire logic [7:0] rd_code_i,   // Character RAM entry.
  input  wire logic [2:0] rd_row_i,    // Row being scanned.
  output logic      [4:0] rd_dots_o    // Dots for that row.
);

  // ----------------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------------
  // Sixteen slots of seven rows of five dots.
  logic [4:0] user_ram [display_pkg::NUM_USER_GLYPHS * display_pkg::NUM_ROWS];
  logic [6:0] wr_index;  // Flat write index.
  logic [6:0] rd_index;  // Flat read index.

  assign wr_index = 7'(wr_slot_i * 7'(display_pkg::NUM_ROWS)) + 7'(wr_row_i);
  assign rd_index = 7'(rd_code_i[3:0] * 7'(display_pkg::NUM_ROWS)) + 7'(rd_row_i);

  // R14 row dots stored
  // Each row write lands in one row of the slot; the eighth row address is ignored.
  always_ff @(posedge sys_clk_i)
  begin
    if (wr_en_i && (wr_row_i < 3'(display_pkg::NUM_ROWS)))
    begin
      user_ram[wr_index] <= wr_dots_i;
    end
  end

  // ----------------------------------------------------------------------
  // Lookup
  // ----------------------------------------------------------------------
  // R15 selector picks source
  // The top bit of the entry chooses a user glyph over the fixed set.
  always_comb
  begin
    if (rd_row_i >= 3'(display_pkg::NUM_ROWS))
    begin
      rd_dots_o = 5'h00;
    end
    else if (rd_code_i[display_pkg::CW_SELECT_BIT])
    begin
      rd_dots_o = user_ram[rd_index];
    end
    else
    begin
      // R2 fixed character codes
      rd_dots_o = display_pkg::font_row(rd_code_i[6:0], rd_row_i);
    end
  end

endmodule

// *** dv/host_port_props.sv ***
// Pin-level checker for the display host port.
// Assumes a bind onto the port and a single clock domain.
`timescale 1ns/10ps
module host_port_props
#(
  parameter int OSC_HALF = 2  // Oscillator half period.
)
(
  input wire logic       sys_clk_i,
  input wire logic       srst_i,
  input wire logic       ce_n_i,
  input wire logic       rd_n_i,
  input wire logic       clk_sel_i,
  input wire logic       data_oe_o,
  input wire logic       disp_clk_o,
  input wire logic       disp_clk_oe_o,
  input wire logic [2:0] row_o,
  input wire logic [4:0] dots_o
);
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (srst_i);
  a_read_drives_bus: assert property ((!ce_n_i && !rd_n_i) [*5] |-> data_oe_o)
    else $error("bus not driven during read");
  a_bus_released: assert property ((ce_n_i || rd_n_i) [*5] |-> !data_oe_o)
    else $error("bus driven outside read");
  a_quiet_reset: assert property ($past(srst_i) |->
    !data_oe_o && !disp_clk_oe_o && dots_o == 5'h00)
    else $error("pins driven after reset");
  a_osc_drives_pin: assert property (clk_sel_i [*5] |-> disp_clk_oe_o)
    else $error("clock pin not driven");
  a_slave_pin_input: assert property (!clk_sel_i [*5] |-> !disp_clk_oe_o)
    else $error("clock pin driven in slave mode");
  a_osc_half_period: assert property (
    (clk_sel_i && disp_clk_oe_o) [*4] ##0 $changed(disp_clk_o)
    |-> ##OSC_HALF ($changed(disp_clk_o) || !disp_clk_oe_o))
    else $error("oscillator period wrong");
  a_row_in_range: assert property (row_o != 3'h7)
    else $error("row beyond seven");
  a_row_steps: assert property ($changed(row_o) |->
    row_o == $past(row_o) + 3'h1 || row_o == 3'h0)
    else $error("row skipped");
endmodule

bind display_host_port host_port_props #(.OSC_HALF(OSC_HALF)) props_u
(
  .sys_clk_i(sys_clk_i), .srst_i(srst_i), .ce_n_i(ce_n_i), .rd_n_i(rd_n_i),
  .clk_sel_i(clk_sel_i), .data_oe_o(data_oe_o), .disp_clk_o(disp_clk_o),
  .disp_clk_oe_o(disp_clk_oe_o), .row_o(row_o), .dots_o(dots_o)
);

// *** dv/host_model.sv ***
// Host side of the display pins: reset, strobes, address and data.
// Assumes the bench calls its tasks from one process only.
`timescale 1ns/10ps
module host_model
(
  input  wire logic       sys_clk_i,  // System clock.
  input  wire logic [7:0] data_o,     // Device read data.
  input  wire logic       data_oe_o,  // Device drives the bus.
  output logic            rst_n_o,    // Display reset pin.
  output logic            ce_n_o,     // Chip enable pin.
  output logic            rd_n_o,     // Read strobe pin.
  output logic            wr_n_o,     // Write strobe pin.
  output logic      [5:0] sel_o,      // Flash select over address.
  output logic      [7:0] bus_o       // Resolved data bus.
);
  logic [7:0] drv_q;   // Last byte the host drove.
  logic       drv_en;  // Host drives the bus.
  initial
  begin
    {rst_n_o, ce_n_o, rd_n_o, wr_n_o} = 4'hF;
    sel_o = 6'h00;
    drv_q = 8'h00;
    drv_en = 1'b0;
  end
  // shared bus; a released bus shows the inverse of the last byte.
  assign bus_o = data_oe_o ? data_o : (drv_en ? drv_q : ~drv_q);
  task automatic hold(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask
  // low pulse, then a wait of over three display clocks.
  task automatic pulse_rst();
    hold(1);
    rst_n_o <= 1'b0;
    hold(4);
    rst_n_o <= 1'b1;
    hold(16);
  endtask
  // address and data, enable, strobe, release.
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    hold(1);
    sel_o <= a;
    drv_q <= d;
    drv_en <= 1'b1;
    hold(2);
    ce_n_o <= 1'b0;
    hold(4);
    wr_n_o <= 1'b0;
    hold(4);
    wr_n_o <= 1'b1;
    hold(4);
    ce_n_o <= 1'b1;
    drv_en <= 1'b0;
    hold(4);
  endtask
  // Read held until the device drives the bus, bounded.
  task automatic rd(input logic [5:0] a, output logic [7:0] d, output logic ok);
    ok = 1'b0;
    hold(1);
    sel_o <= a;
    ce_n_o <= 1'b0;
    rd_n_o <= 1'b0;
    for (int n = 0; n < 12 && !ok; n++)
    begin
      hold(1);
      ok = (data_oe_o === 1'b1);
      d = data_o;
    end
    rd_n_o <= 1'b1;
    ce_n_o <= 1'b1;
    hold(6);
  endtask
endmodule

// *** dv/display_host_port_bench.sv ***
// Self-checking bench of the display host port.
// Assumes the host model and the bound pin checker.
`timescale 1ns/10ps
module display_host_port_bench;
  logic       sys_clk_i, srst_i, clk_sel_i, disp_clk_i, rst_n, ce_n, rd_n, wr_n;
  logic       data_oe, clk_o, clk_oe, ok;
  logic [5:0] sel;
  logic [7:0] bus, data, d, v;
  logic [2:0] digit, row, row0;
  logic [4:0] dots, g [7];
  int         error_cnt, comparisons;
  display_host_port #(.OSC_HALF(2), .BLINK_LEN(2)) dut_u
  (
    .sys_clk_i(sys_clk_i), .srst_i(srst_i), .disp_rst_n_i(rst_n), .ce_n_i(ce_n),
    .rd_n_i(rd_n), .wr_n_i(wr_n), .flash_sel_i(sel[5]), .addr_i(sel[4:0]),
    .data_i(bus), .data_o(data), .data_oe_o(data_oe), .clk_sel_i(clk_sel_i),
    .disp_clk_i(disp_clk_i), .disp_clk_o(clk_o), .disp_clk_oe_o(clk_oe),
    .digit_o(digit), .row_o(row), .dots_o(dots)
  );
  host_model host_u
  (
    .sys_clk_i(sys_clk_i), .data_o(data), .data_oe_o(data_oe), .rst_n_o(rst_n),
    .ce_n_o(ce_n), .rd_n_o(rd_n), .wr_n_o(wr_n), .sel_o(sel), .bus_o(bus)
  );
  always #4 sys_clk_i = ~sys_clk_i;
  // Expected control read: busy in bit 6, pass in bit 5.
  function automatic logic [7:0] exp_ctrl(input logic [7:0] w, input logic busy);
    return {1'b0, busy, ~busy, w[4:0]};
  endfunction
  task automatic stop_test();
    $display("counts: %0d comparisons, %0d mismatches", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
    begin
      $display("TB: PASS");
    end
    else
    begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    comparisons++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  // Reads one selector address and compares the value.
  task automatic rd_chk(input logic [5:0] a, input logic [7:0] exp);
    host_u.rd(a, v, ok);
    if (!ok)
    begin
      error_cnt++;
      $display("mismatch at %0t: read timed out", $time);
      stop_test();
    end
    check(v, exp, "read");
  endtask
  // Waits, bounded, until the scan shows the given digit and row.
  task automatic wait_scan(input logic [2:0] w_dig, input logic [2:0] w_row);
    for (int n = 0; n < 4000 && !(digit === w_dig && row === w_row); n++)
    begin
      host_u.hold(1);
    end
    if (digit !== w_dig || row !== w_row)
    begin
      error_cnt++;
      $display("mismatch at %0t: scan wait timed out", $time);
      stop_test();
    end
  endtask
  initial
  begin
    {sys_clk_i, srst_i, clk_sel_i, disp_clk_i} = 4'h6;
    error_cnt = 0;
    comparisons = 0;
    void'($urandom(32'h1B15));
    repeat (3) @(posedge sys_clk_i);
    srst_i <= 1'b0;
    host_u.pulse_rst();
    rd_chk(6'h30, 8'h00);
    $display("test reset value done");
    host_u.wr(6'h30, 8'h40);
    rd_chk(6'h30 | 6'($urandom % 8), exp_ctrl(8'h40, 1'b1));
    host_u.hold(900);
    rd_chk(6'h30 | 6'($urandom % 8), exp_ctrl(8'h40, 1'b0));
    $display("test self-test done");
    for (int i = 0; i < 8; i++)
    begin
      d = (8'($urandom) & 8'hB8) | 8'(i);
      host_u.wr(6'h30, d);
      rd_chk(6'h30 | 6'($urandom % 8), exp_ctrl(d, 1'b0));
    end
    $display("test control codes done");
    d = 8'($urandom % 16);
    host_u.wr(6'h20, d);
    for (int r = 0; r < 7; r++)
    begin
      g[r] = 5'($urandom);
      host_u.wr(6'h28 + 6'(r), {3'h0, g[r]});
    end
    rd_chk(6'h2B, 8'h00);
    host_u.wr(6'h38, 8'h80 | d);
    host_u.wr(6'h30, 8'h00);
    for (int r = 0; r < 7; r++)
    begin
      wait_scan(3'h0, 3'(r));
      check({3'h0, dots}, {3'h0, g[r]}, "glyph row");
    end
    wait_scan(3'h1, 3'h3);
    check({3'h0, dots}, 8'h00, "blank code");
    host_u.wr(6'h04, 8'h01);
    host_u.wr(6'h30, 8'h1B);
    rd_chk(6'h30, 8'h3B);
    $display("test glyph and features done");
    check({7'h00, clk_oe}, 8'h01, "clock drive");
    row0 = row;
    clk_sel_i <= 1'b0;
    for (int t = 0; t < 80; t++)
    begin
      host_u.hold(3);
      disp_clk_i <= ~disp_clk_i;
    end
    check({7'h00, clk_oe}, 8'h00, "clock slave");
    check({7'h00, row !== row0}, 8'h01, "slave scan");
    host_u.hold(4);
    row0 = row;
    host_u.hold(100);
    check({5'h00, row}, {5'h00, row0}, "slave stall");
    clk_sel_i <= 1'b1;
    $display("test clock modes done");
    host_u.pulse_rst();
    rd_chk(6'h30, 8'h00);
    $display("test display reset done");
    stop_test();
  end
endmodule
